/* File: qcr_pkg.sv */
// shared constants and types for the quad continuous read path
package qcr_pkg;
  localparam logic [7:0]  OP_FULL_READ    = 8'heb;   // full-address quad read
  localparam logic [7:0]  OP_ALIGN_READ   = 8'he7;   // double-word aligned quad read
  localparam int          OPCODE_CLKS     = 8;       // opcode bits, one per clock
  localparam int          ADDR_CLKS       = 6;       // address nibbles
  localparam int          ADDR_W          = 24;      // address width
  localparam logic [23:0] ADDR_TOP        = 24'h3fffff; // last byte of the array
  localparam logic [23:0] ADDR_BOTTOM     = 24'h000000; // wrap target
  localparam logic [1:0]  ALIGN_LOW_BITS  = 2'b00;   // forced low address bits
  localparam int          STAT5_ALIGN_BIT = 0;       // word_align_select position
  localparam int          STAT5_DC_LSB    = 4;       // dummy_count_field low bit
  localparam int          STAT5_DC_MSB    = 6;       // dummy_count_field high bit
  localparam logic [2:0]  DC_MAX_CODE     = 3'h4;    // highest legal dummy code
  localparam logic [7:0]  MODE_KEEP_DEF   = 8'ha0;   // default continuous mode key
  localparam logic [7:0]  STAT5_RST       = 8'h00;   // fifth_status_register default

  // link phases
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DATA   = 3'b100,
    ST_IGNORE = 3'b101
  } qcr_phase_type;
endpackage : qcr_pkg

/* File: qcr_quad_read.sv */
// quad i/o read path with continuous fetch mode, sampled link clock
`timescale 1ns/1ps
module qcr_quad_read
  import qcr_pkg::*;
#(
  parameter logic [7:0] MODE_KEEP = MODE_KEEP_DEF   // mode value that holds continuous mode
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // serial link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  // status register and array access
  input  wire logic [7:0] fifth_status_register,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0] mem_data,
  // status outputs
  output logic            continuous_fetch_mode,
  output logic            cmd_reject
);

  // elaboration check: an unknown mode key could never match the mode field
  if ($isunknown(MODE_KEEP)) begin : g_bad_key
    $error("mode key must be a known byte");
  end

  // whole module state
  typedef struct packed {
    logic [1:0]    sck_s;      // sync stage pair for sck
    logic [1:0]    cs_s;       // sync stage pair for chip select
    logic [7:0]    io_s0;      // both io sync stages, two nibbles packed
    logic          sck_d;      // previous synced sck
    qcr_phase_type phase;      // link phase
    logic [3:0]    cnt;        // clocks left in phase
    logic [7:0]    opcode;     // opcode shift register
    logic          aligned;    // current read is aligned
    logic [23:0]   addr;       // read address
    logic [7:0]    mode;       // mode field
    logic          keep;       // continuous mode armed
    logic [7:0]    byte_r;     // byte being sent
    logic          half;       // low nibble pending
    logic [3:0]    io_out;     // driven nibble
    logic [3:0]    io_oe;      // output enables
    logic          reject;     // unsupported opcode seen
  } qcr_state_type;

  qcr_state_type st_r;
  qcr_state_type st_nxt;

  // dummy code to clock count, includes the two mode clocks
  function automatic logic [3:0] dummy_clks(input logic [2:0] code);
    logic [2:0] c;
    c = (code > DC_MAX_CODE) ? DC_MAX_CODE : code;
    dummy_clks = {c, 1'b0} + 4'h2;
  endfunction

  // synced levels and edges
  logic       sck_q;
  logic       cs_q;
  logic [3:0] io_q;
  logic       rise;
  logic       fall;
  assign sck_q = st_r.sck_s[1];
  assign cs_q  = st_r.cs_s[1];
  assign io_q  = st_r.io_s0[7:4];
  assign rise  = sck_q & ~st_r.sck_d;
  assign fall  = ~sck_q & st_r.sck_d;

  // next-state logic
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sck_s = {st_r.sck_s[0], sck};
    st_nxt.cs_s  = {st_r.cs_s[0], cs_n};
    st_nxt.io_s0 = {st_r.io_s0[3:0], io_in};
    st_nxt.sck_d = sck_q;
    if (cs_q) begin
      // frame ended: release lines and settle mode
      if (st_r.phase != ST_IDLE) begin
        st_nxt.keep = (st_r.phase == ST_DATA) && (st_r.mode == MODE_KEEP);
      end
      st_nxt.phase = ST_IDLE;
      st_nxt.io_oe = 4'h0;
      st_nxt.half  = 1'b0;
    end else begin
      case (st_r.phase)
        // frame start: skip opcode when continuous mode armed
        ST_IDLE: begin
          st_nxt.reject = 1'b0;
          if (st_r.keep) begin
            st_nxt.phase = ST_ADDR;
            st_nxt.cnt   = 4'(ADDR_CLKS);
          end else begin
            st_nxt.phase = ST_OPCODE;
            st_nxt.cnt   = 4'(OPCODE_CLKS);
          end
        end
        // opcode on io0, msb first
        ST_OPCODE: begin
          if (rise) begin
            st_nxt.opcode = {st_r.opcode[6:0], io_q[0]};
            st_nxt.cnt    = st_r.cnt - 4'h1;
            if (st_r.cnt == 4'h1) begin
              st_nxt.cnt = 4'(ADDR_CLKS);
              if ({st_r.opcode[6:0], io_q[0]} == OP_ALIGN_READ) begin
                st_nxt.aligned = 1'b1;
                st_nxt.phase   = ST_ADDR;
              end else if ({st_r.opcode[6:0], io_q[0]} == OP_FULL_READ) begin
                st_nxt.aligned = fifth_status_register[STAT5_ALIGN_BIT];
                st_nxt.phase   = ST_ADDR;
              end else begin
                st_nxt.reject = 1'b1;
                st_nxt.phase  = ST_IGNORE;
              end
            end
          end
        end
        // address nibbles, io3 carries the high bit
        ST_ADDR: begin
          if (rise) begin
            st_nxt.addr = {st_r.addr[19:0], io_q};
            st_nxt.cnt  = st_r.cnt - 4'h1;
            if (st_r.cnt == 4'h1) begin
              if (st_r.aligned) begin
                st_nxt.addr[1:0] = ALIGN_LOW_BITS;
              end
              st_nxt.phase = ST_DUMMY;
              st_nxt.cnt   = dummy_clks(fifth_status_register[STAT5_DC_MSB:STAT5_DC_LSB]);
            end
          end
        end
        // dummies; first two carry the mode field
        ST_DUMMY: begin
          if (rise) begin
            st_nxt.cnt = st_r.cnt - 4'h1;
            if (st_r.cnt > (dummy_clks(fifth_status_register[STAT5_DC_MSB:STAT5_DC_LSB])
                            - 4'h2)) begin
              st_nxt.mode = {st_r.mode[3:0], io_q};
            end
            if (st_r.cnt == 4'h1) begin
              st_nxt.phase  = ST_DATA;
              st_nxt.byte_r = mem_data;
              st_nxt.half   = 1'b0;
            end
          end
        end
        // data nibbles launched on falling edges
        ST_DATA: begin
          if (fall) begin
            st_nxt.io_oe = 4'hf;
            if (!st_r.half) begin
              st_nxt.io_out = st_r.byte_r[7:4];
              st_nxt.half   = 1'b1;
              st_nxt.addr   = (st_r.addr == ADDR_TOP) ? ADDR_BOTTOM
                              : st_r.addr + 24'h000001;
            end else begin
              st_nxt.io_out = st_r.byte_r[3:0];
              st_nxt.half   = 1'b0;
              st_nxt.byte_r = mem_data;
            end
          end
        end
        // unsupported opcode: wait for chip select high
        ST_IGNORE: begin
          st_nxt.io_oe = 4'h0;
        end
        default: begin
          st_nxt.phase = ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r       <= '0;
      st_r.sck_s <= 2'b00;
      st_r.cs_s  <= 2'b11;
      st_r.phase <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flops
  assign io_out                = st_r.io_out;
  assign io_oe                 = st_r.io_oe;
  assign mem_addr              = st_r.addr;
  assign continuous_fetch_mode = st_r.keep;
  assign cmd_reject            = st_r.reject;

  // chip select high releases the lines on the next cycle
  property p_release;
    @(posedge clk_sys) disable iff (rst) $rose(cs_q) |=> (io_oe == 4'h0);
  endproperty
  a_release: assert property (p_release) else $error("lines not released");

  // no drive outside data phase
  property p_oe_data;
    @(posedge clk_sys) disable iff (rst) (io_oe != 4'h0) |-> (st_r.phase == ST_DATA);
  endproperty
  a_oe_data: assert property (p_oe_data) else $error("drive outside data");

  // aligned read low bits zero after address
  property p_align;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_DUMMY && st_r.aligned) |-> (mem_addr[1:0] == 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("aligned address low bits set");

  // continuous mode frame starts at address
  property p_skip_op;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_IDLE && !cs_q && st_r.keep) |=> (st_r.phase == ST_ADDR);
  endproperty
  a_skip_op: assert property (p_skip_op) else $error("opcode not skipped");

  // no continuous mode expects opcode
  property p_need_op;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_IDLE && !cs_q && !st_r.keep) |=> (st_r.phase == ST_OPCODE);
  endproperty
  a_need_op: assert property (p_need_op) else $error("opcode phase missing");

  // wrap at top address
  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_DATA && fall && !st_r.half && !cs_q && mem_addr == ADDR_TOP)
      |=> (mem_addr == ADDR_BOTTOM);
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  // dummy count is nonzero and within range
  property p_dummy;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_DUMMY) |-> (st_r.cnt <= 4'ha && st_r.cnt != 4'h0);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy count out of range");

  // mode mismatch clears continuous mode
  property p_mode_clear;
    @(posedge clk_sys) disable iff (rst)
      (cs_q && st_r.phase == ST_DATA && st_r.mode != MODE_KEEP) |=> !continuous_fetch_mode;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");

  c_data:   cover property (@(posedge clk_sys) disable iff (rst) st_r.phase == ST_DATA);
  c_cont:   cover property (@(posedge clk_sys) disable iff (rst) $rose(continuous_fetch_mode));
  c_reject: cover property (@(posedge clk_sys) disable iff (rst) $rose(cmd_reject));
  c_abort:  cover property (@(posedge clk_sys) disable iff (rst) $rose(cs_q) && st_r.half);
  c_align:  cover property (@(posedge clk_sys) disable iff (rst)
                            st_r.phase == ST_DUMMY && st_r.aligned);

  // high nibble of the byte goes out on the first data fall, all lines driven
  property p_high_first;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_DATA && fall && !st_r.half && !cs_q)
      |=> (io_out == $past(st_r.byte_r[7:4]) && io_oe == 4'hf);
  endproperty
  a_high_first: assert property (p_high_first) else $error("high nibble not first");

  // low nibble follows on the next fall
  property p_low_second;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_DATA && fall && st_r.half && !cs_q)
      |=> (io_out == $past(st_r.byte_r[3:0]));
  endproperty
  a_low_second: assert property (p_low_second) else $error("low nibble not second");

  // the four lines turn around together, never a partial drive
  property p_all_lines;
    @(posedge clk_sys) disable iff (rst)
      (io_oe == 4'h0) || (io_oe == 4'hf);
  endproperty
  a_all_lines: assert property (p_all_lines) else $error("partial line drive");

  // last address nibble hands over to the dummy clocks
  property p_to_dummy;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == ST_ADDR && rise && st_r.cnt == 4'h1 && !cs_q)
      |=> (st_r.phase == ST_DUMMY);
  endproperty
  a_to_dummy: assert property (p_to_dummy) else $error("dummy phase not entered");

endmodule // qcr_quad_read

/* File: qcr_host.sv */
// host-side link model driving the quad read path
`timescale 1ns/1ps
module qcr_host (
  // system clock for edge alignment
  input  wire logic       clk_sys,
  // link pins toward the device
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in,
  // device drive back
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [7:0] rx[$];  // sampled {io_oe, io_out} per data clock
  // idle link: clock low, chip deselected
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h0;
  end
  // half link period; the link clock runs free of the system clock
  task automatic hp();
    #62.5;
  endtask
  // one read frame; the opcode phase only when wop is set
  task automatic frame(input bit wop, input logic [7:0] op, input logic [23:0] a,
                       input logic [7:0] md, input int nd, input int nn);
    int k;
    rx.delete();
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 0; i < (wop ? 8 : 0) + 6 + nd + nn; i++) begin
      k = wop ? i : i + 8;
      if (k < 8) begin
        io_in <= {3'b000, op[7-k]};
      end else if (k < 14) begin
        io_in <= a[23-4*(k-8) -: 4];
      end else if (k < 14 + nd) begin
        io_in <= (k == 14) ? md[7:4] : (k == 15) ? md[3:0] : 4'h0;
      end else begin
        io_in <= ~io_in;
      end
      hp();
      sck <= 1'b1;
      // data sampled on the rise, launched on the fall before
      if (k >= 14 + nd) begin
        rx.push_back({io_oe, io_out});
      end
      hp();
      sck <= 1'b0;
    end
    hp();
    cs_n <= 1'b1;
    hp();
    hp();
  endtask
endmodule // qcr_host

/* File: quad_io_continuous_read_bench.sv */
// self-checking bench for the quad continuous read path
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module quad_io_continuous_read_bench;
  import qcr_pkg::*;
  logic        clk_sys;          // system clock
  logic        rst;              // async reset
  logic        sck;              // link clock
  logic        cs_n;             // chip select
  logic [3:0]  io_in;            // host nibble
  logic [3:0]  io_out;           // device nibble
  logic [3:0]  io_oe;            // device enables
  logic [7:0]  stat;             // fifth status register
  logic [23:0] mem_addr;         // array address
  logic [7:0]  mem_data;         // array byte
  logic        continuous_fetch_mode;
  logic        cmd_reject;
  int          num_errors = 0;
  int          samples_checked = 0;
  // array byte mixes the top byte in so a wrap is visible
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[23:16];
  endfunction
  assign mem_data = mem(mem_addr);
  qcr_host h (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .io_in(io_in),
              .io_out(io_out), .io_oe(io_oe));
  qcr_quad_read dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .fifth_status_register(stat),
    .mem_addr(mem_addr), .mem_data(mem_data),
    .continuous_fetch_mode(continuous_fetch_mode), .cmd_reject(cmd_reject));
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one frame, then judge each nibble; e is the expected first byte address
  task automatic rd(input bit wop, input logic [7:0] op, input logic [23:0] a,
                    input logic [23:0] e, input logic [7:0] md, input logic [7:0] st,
                    input int nn, input bit drv);
    logic [7:0] b;
    @(posedge clk_sys);
    stat <= st;
    h.frame(wop, op, a, md, 2 * int'(st[6:4]) + 2, nn);
    `CHK(h.rx.size(), nn)
    for (int j = 0; j < nn; j++) begin
      b = mem(e);
      if (drv) begin
        `CHK(h.rx[j], {4'hf, (j[0] ? b[3:0] : b[7:4])})
      end else begin
        `CHK(h.rx[j][7:4], 4'h0)
      end
      if (j[0]) begin
        e = (e == ADDR_TOP) ? ADDR_BOTTOM : e + 24'h1;
      end
    end
    `CHK(io_oe, 4'h0)
  endtask
  // first read enters continuous mode
  task automatic t_first();
    rd(1, OP_FULL_READ, 24'h000101, 24'h000101, 8'ha0, 8'h00, 4, 1);
    `CHK(continuous_fetch_mode, 1'b1)
    $display("test first done");
  endtask
  // opcode-less read across the top of the array
  task automatic t_cont();
    rd(0, 8'h00, 24'h3ffffe, 24'h3ffffe, 8'ha0, 8'h20, 6, 1);
    `CHK(continuous_fetch_mode, 1'b1)
    $display("test continuous done");
  endtask
  // other mode value leaves continuous mode; nonzero byte so data is visible
  task automatic t_exit();
    rd(0, 8'h00, 24'h000234, 24'h000234, 8'h00, 8'h40, 2, 1);
    `CHK(continuous_fetch_mode, 1'b0)
    $display("test exit done");
  endtask
  // aligned opcode, and full opcode with alignment selected
  task automatic t_align();
    rd(1, OP_ALIGN_READ, 24'h000107, 24'h000104, 8'h00, 8'h10, 2, 1);
    rd(1, OP_FULL_READ, 24'h000107, 24'h000104, 8'h00, 8'h31, 2, 1);
    $display("test align done");
  endtask
  // mid-byte abort, then an unknown opcode is refused
  task automatic t_abort();
    rd(1, OP_FULL_READ, 24'h000356, 24'h000356, 8'h00, 8'h00, 3, 1);
    `CHK(cmd_reject, 1'b0)
    rd(1, 8'h55, 24'h000300, 24'h000300, 8'ha0, 8'h00, 4, 0);
    `CHK(cmd_reject, 1'b1)
    `CHK(continuous_fetch_mode, 1'b0)
    $display("test abort done");
  endtask
  // hang guard
  initial begin
    #200us;
    num_errors++;
    close_out();
  end
  // reset, then the scenarios in order
  initial begin
    rst  = 1'b1;
    stat = STAT5_RST;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_first();
    t_cont();
    t_exit();
    t_align();
    t_abort();
    close_out();
  end
endmodule // quad_io_continuous_read_bench
